//--- hdl/i2c_master_seq.sv
/*
 * I2C master sequencer: target-select and status registers, two-entry
 * byte queues each way, and the open-drain bit engine.
 * Assumes the CPU port runs on REF_CLK and the bus has pull-ups.
 */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// two-entry byte queue with valid/ready on both sides
// ----------------------------------------------------------------
module pair_buffer
    import i2c_seq_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       flush,
    input  wire logic       in_valid,
    input  wire logic [7:0] in_data,
    output logic            in_ready,
    output logic            out_valid,
    output logic [7:0]      out_data,
    input  wire logic       out_ready,
    output logic [1:0]      level
);
    logic [7:0] mem_reg [2];
    logic [7:0] mem_next [2];
    logic       wp_reg, wp_next, rp_reg, rp_next;
    logic [1:0] cnt_reg, cnt_next;
    logic       push, pop;

    // ready looks only at the count, so no path runs through the queue
    assign in_ready  = cnt_reg != 2'h2;
    assign out_valid = cnt_reg != 2'h0;
    assign out_data  = mem_reg[rp_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign level     = !out_valid ? LVL_EMPTY : (in_ready ? LVL_HALF : LVL_FULL);

    // pointer and count update, flush wins over everything
    always_comb begin
        mem_next = mem_reg;
        wp_next  = wp_reg;
        rp_next  = rp_reg;
        cnt_next = cnt_reg + 2'(push) - 2'(pop);
        if (push) begin
            mem_next[wp_reg] = in_data;
            wp_next          = !wp_reg;
        end
        if (pop) begin
            rp_next = !rp_reg;
        end
        if (flush) begin
            wp_next  = 1'b0;
            rp_next  = 1'b0;
            cnt_next = 2'h0;
        end
    end

    // storage registers
    always_ff @(posedge clk) begin
        if (rst) begin
            mem_reg <= '{8'h00, 8'h00};
            wp_reg  <= 1'b0;
            rp_reg  <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            mem_reg <= mem_next;
            wp_reg  <= wp_next;
            rp_reg  <= rp_next;
            cnt_reg <= cnt_next;
        end
    end
endmodule

// Overview of operation
// - target write starts transaction to address
// - direction one reads, bytes into queue
// - direction zero writes bytes from queue
// - busy flag while active, queue drained
// - missing ack sets sticky flag, halts
// - receive pending set while queue nonempty
// - transmit empty set when queue empties
// - level field 00, 10, 11 codes
// - simultaneous data write and read flagged
// - write into full queue flagged
// - master acks each received byte but the last
// - nack after programmed count ends read
// - target rewrite mid-transfer gives repeated start
// - read ends after count plus one bytes
// - enable bit gates launching a transfer
// - empty transmit queue stops a write
// - error during write flushes transmit queue
module i2c_master_seq
    import i2c_seq_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RST,
    input  wire logic [7:0] SFR_ADDR,
    input  wire logic       SFR_WR,
    input  wire logic       SFR_RD,
    input  wire logic [7:0] SFR_WDATA,
    output logic      [7:0] SFR_RDATA,
    input  wire logic       SCL_I,
    output logic            SCL_O,
    output logic            SCL_OE_N,
    input  wire logic       SDA_I,
    output logic            SDA_O,
    output logic            SDA_OE_N
);
    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    seq_state_t state_reg, state_next;
    logic [7:0] mode_reg, mode_next, target_reg, target_next;
    logic [7:0] stat_reg, stat_next, rdata_reg, rdata_next, stat_set;
    logic       pend_reg, pend_next, txhad_reg, txhad_next;
    logic [1:0] qtr_reg, qtr_next;
    logic [6:0] tick_reg, tick_next, qlen;
    logic [2:0] bit_reg, bit_next;
    logic [7:0] shift_reg, shift_next;
    logic [4:0] rxcnt_reg, rxcnt_next;
    logic       addr_ph_reg, addr_next, dir_reg, dir_next;
    logic       nack_reg, nack_next, scl_oe_n_reg, scl_next;
    logic       sda_oe_n_reg, sda_next, low_reg;
    logic       scl_s1, scl_s2, sda_s1, sda_s2;
    logic       tick_done, hold, stall, advance, receiving, last_byte;
    logic       rx_push, tx_pop, nack_ev, fin;
    logic       tx_wr, rx_rd, tgt_wr, stat_wr, coll;
    logic       tx_in_ready, tx_out_valid, rx_in_ready, rx_out_valid;
    logic [7:0] tx_out_data, rx_out_data;
    logic [1:0] tx_level, rx_level;

    // ----------------------------------------------------------------
    // pin synchronisers and port decode
    // ----------------------------------------------------------------
    // two stages before anything looks at the bus lines
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
        end else begin
            scl_s1 <= SCL_I;
            scl_s2 <= scl_s1;
            sda_s1 <= SDA_I;
            sda_s2 <= sda_s1;
        end
    end

    assign tx_wr   = SFR_WR && SFR_ADDR == ADDR_TXBUF;
    assign rx_rd   = SFR_RD && SFR_ADDR == ADDR_RXBUF;
    assign tgt_wr  = SFR_WR && SFR_ADDR == ADDR_TARGET;
    assign stat_wr = SFR_WR && SFR_ADDR == ADDR_STATUS;
    // separate buffer addresses, so a clash is both strobes at once on either byte buffer
    assign coll    = SFR_WR && SFR_RD && (SFR_ADDR == ADDR_TXBUF || SFR_ADDR == ADDR_RXBUF);

    // outgoing queue; a failed write empties it
    pair_buffer u_txq (
        .clk       (REF_CLK),
        .rst       (RST),
        .flush     (nack_ev && !dir_reg),
        .in_valid  (tx_wr),
        .in_data   (SFR_WDATA),
        .in_ready  (tx_in_ready),
        .out_valid (tx_out_valid),
        .out_data  (tx_out_data),
        .out_ready (tx_pop),
        .level     (tx_level)
    );

    // incoming queue; a full queue stalls the bus with scl released high in the ack slot
    pair_buffer u_rxq (
        .clk       (REF_CLK),
        .rst       (RST),
        .flush     (1'b0),
        .in_valid  (rx_push),
        .in_data   (shift_reg),
        .in_ready  (rx_in_ready),
        .out_valid (rx_out_valid),
        .out_data  (rx_out_data),
        .out_ready (rx_rd),
        .level     (rx_level)
    );

    // ----------------------------------------------------------------
    // quarter-period timing
    // ----------------------------------------------------------------
    assign qlen      = QTR_BASE << mode_reg[MODE_RATE_HI:MODE_RATE_LO];
    assign tick_done = tick_reg == qlen - 7'd1;
    assign receiving = !addr_ph_reg && dir_reg;
    assign last_byte = rxcnt_reg == mode_reg[MODE_RCT_HI:0];
    // a target holding scl low stretches the high quarter
    assign hold      = qtr_reg == 2'd2 && scl_oe_n_reg && !scl_s2;
    assign stall     = state_reg == S_ACK && qtr_reg == 2'd3 && receiving && !rx_in_ready;
    assign advance   = state_reg != S_IDLE && tick_done && !hold && !stall;

    // ----------------------------------------------------------------
    // bit engine
    // ----------------------------------------------------------------
    // each bit is four quarters: set data, raise scl, sample, drop scl
    always_comb begin
        state_next = state_reg;
        qtr_next   = qtr_reg;
        tick_next  = tick_done ? tick_reg : tick_reg + 7'd1;
        bit_next   = bit_reg;
        shift_next = shift_reg;
        rxcnt_next = rxcnt_reg;
        addr_next  = addr_ph_reg;
        dir_next   = dir_reg;
        nack_next  = nack_reg;
        scl_next   = scl_oe_n_reg;
        sda_next   = sda_oe_n_reg;
        rx_push    = 1'b0;
        tx_pop     = 1'b0;
        nack_ev    = 1'b0;
        fin        = 1'b0;
        if (advance) begin
            tick_next = 7'd0;
            qtr_next  = qtr_reg + 2'd1;
        end
        unique case (state_reg)
            S_IDLE: begin
                qtr_next  = 2'd0;
                tick_next = 7'd0;
                if (pend_reg) begin
                    state_next = S_START;
                end
            end
            S_START: if (advance) begin
                unique case (qtr_reg)
                    2'd0: sda_next = 1'b1;
                    2'd1: scl_next = 1'b1;
                    2'd2: sda_next = 1'b0;
                    2'd3: begin
                        scl_next   = 1'b0;
                        state_next = S_BIT;
                        bit_next   = 3'd7;
                        shift_next = target_reg;
                        addr_next  = 1'b1;
                        dir_next   = target_reg[TGT_DIR];
                        rxcnt_next = 5'd0;
                    end
                endcase
            end
            S_BIT: if (advance) begin
                unique case (qtr_reg)
                    2'd0: sda_next = receiving || shift_reg[7];
                    2'd1: scl_next = 1'b1;
                    2'd2: shift_next = {shift_reg[6:0], sda_s2};
                    2'd3: begin
                        scl_next = 1'b0;
                        bit_next = bit_reg - 3'd1;
                        if (bit_reg == 3'd0) begin
                            state_next = S_ACK;
                        end
                    end
                endcase
            end
            S_ACK: if (advance) begin
                unique case (qtr_reg)
                    2'd0: sda_next = receiving ? last_byte : 1'b1;
                    2'd1: scl_next = 1'b1;
                    2'd2: nack_next = sda_s2;
                    2'd3: begin
                        scl_next   = 1'b0;
                        bit_next   = 3'd7;
                        state_next = S_BIT;
                        addr_next  = 1'b0;
                        if (receiving) begin
                            rx_push    = 1'b1;
                            rxcnt_next = rxcnt_reg + 5'd1;
                            fin        = last_byte;
                        end else if (nack_reg) begin
                            nack_ev = 1'b1;
                            fin     = 1'b1;
                        end else if (!(addr_ph_reg && dir_reg)) begin
                            if (tx_out_valid) begin
                                tx_pop     = 1'b1;
                                shift_next = tx_out_data;
                            end else begin
                                fin = 1'b1;
                            end
                        end
                        if (fin) begin
                            state_next = pend_reg ? S_START : S_STOP;
                        end
                    end
                endcase
            end
            S_STOP: if (advance) begin
                unique case (qtr_reg)
                    2'd0: sda_next = 1'b0;
                    2'd1: scl_next = 1'b1;
                    2'd2: sda_next = 1'b1;
                    2'd3: state_next = S_IDLE;
                endcase
            end
            default: state_next = S_IDLE;
        endcase
    end

    // engine registers; lines reset released
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            state_reg    <= S_IDLE;
            qtr_reg      <= 2'd0;
            tick_reg     <= 7'd0;
            bit_reg      <= 3'd7;
            shift_reg    <= RESET_BYTE;
            rxcnt_reg    <= 5'd0;
            addr_ph_reg  <= 1'b0;
            dir_reg      <= 1'b0;
            nack_reg     <= 1'b0;
            scl_oe_n_reg <= 1'b1;
            sda_oe_n_reg <= 1'b1;
            low_reg      <= 1'b0;
        end else begin
            state_reg    <= state_next;
            qtr_reg      <= qtr_next;
            tick_reg     <= tick_next;
            bit_reg      <= bit_next;
            shift_reg    <= shift_next;
            rxcnt_reg    <= rxcnt_next;
            addr_ph_reg  <= addr_next;
            dir_reg      <= dir_next;
            nack_reg     <= nack_next;
            scl_oe_n_reg <= scl_next;
            sda_oe_n_reg <= sda_next;
            low_reg      <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // registers seen by the CPU
    // ----------------------------------------------------------------
    // sticky flags: a set in the clearing cycle wins over the clear
    always_comb begin
        mode_next   = SFR_WR && SFR_ADDR == ADDR_MODE ? SFR_WDATA : mode_reg;
        target_next = tgt_wr ? SFR_WDATA : target_reg;
        // launch only while enabled; a rewrite when busy queues a restart
        pend_next   = (tgt_wr && mode_reg[MODE_EN])
                      || (pend_reg && !(state_reg != S_START && state_next == S_START));
        txhad_next  = tx_out_valid;
        stat_set             = 8'h00;
        stat_set[ST_NOACK]   = nack_ev;
        stat_set[ST_RXPEND]  = rx_out_valid;
        stat_set[ST_TXEMPTY] = txhad_reg && !tx_out_valid;
        stat_set[ST_COLL]    = coll;
        stat_set[ST_OVER]    = tx_wr && !tx_in_ready;
        stat_next = (stat_reg & ~(stat_wr ? ~SFR_WDATA & STICKY_MASK : 8'h00)) | stat_set;
        rdata_next = rdata_reg;
        if (SFR_RD) begin
            case (SFR_ADDR)
                ADDR_RXBUF:  rdata_next = rx_out_data;
                ADDR_MODE:   rdata_next = mode_reg;
                ADDR_TARGET: rdata_next = target_reg;
                // busy and level are live, the rest sticky
                ADDR_STATUS: rdata_next = {state_reg != S_IDLE, stat_reg[6:4],
                                           dir_reg ? rx_level : tx_level, stat_reg[1:0]};
                default:     rdata_next = RESET_BYTE;
            endcase
        end
    end

    // register file storage
    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            mode_reg   <= RESET_BYTE;
            target_reg <= RESET_BYTE;
            stat_reg   <= RESET_BYTE;
            rdata_reg  <= RESET_BYTE;
            pend_reg   <= 1'b0;
            txhad_reg  <= 1'b0;
        end else begin
            mode_reg   <= mode_next;
            target_reg <= target_next;
            stat_reg   <= stat_next;
            rdata_reg  <= rdata_next;
            pend_reg   <= pend_next;
            txhad_reg  <= txhad_next;
        end
    end

    assign SFR_RDATA = rdata_reg;
    assign SCL_O     = low_reg;
    assign SDA_O     = low_reg;
    assign SCL_OE_N  = scl_oe_n_reg;
    assign SDA_OE_N  = sda_oe_n_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RST);

    sequence s_ack_open;
        state_reg == S_ACK && qtr_reg == 2'd0 && advance && receiving;
    endsequence
    sequence s_ack_close;
        state_reg == S_ACK && qtr_reg == 2'd3 && advance;
    endsequence

    a_launch_start: assert property (tgt_wr && mode_reg[MODE_EN] && state_reg == S_IDLE
        |-> ##2 state_reg == S_START) else $error("target write did not launch");
    a_launch_gated: assert property (tgt_wr && !mode_reg[MODE_EN] && !pend_reg
        |=> !pend_reg) else $error("launch while disabled");
    a_ack_drive: assert property (s_ack_open and !last_byte |=> !sda_oe_n_reg)
        else $error("no master ack");
    a_nack_drive: assert property (s_ack_open and last_byte |=> sda_oe_n_reg)
        else $error("no master nack on last byte");
    a_read_end: assert property (s_ack_close and receiving && last_byte
        |=> state_reg inside {S_STOP, S_START}) else $error("read overran count");
    a_restart_go: assert property (s_ack_close and fin && pend_reg
        |=> state_reg == S_START) else $error("no repeated start");
    a_tx_starve: assert property (s_ack_close and !dir_reg && !nack_reg && !tx_out_valid
        && !pend_reg |=> state_reg == S_STOP) else $error("write went on without data");
    a_nack_flush: assert property (nack_ev && !dir_reg
        |=> stat_reg[ST_NOACK] && !tx_out_valid) else $error("missing ack not handled");
    a_nack_keep: assert property (stat_reg[ST_NOACK] && !(stat_wr && !SFR_WDATA[ST_NOACK])
        |=> stat_reg[ST_NOACK]) else $error("missing-ack flag lost");
    a_rx_pending: assert property (rx_out_valid |=> stat_reg[ST_RXPEND])
        else $error("receive pending not set");
    a_tx_empty: assert property ($fell(tx_out_valid) |=> stat_reg[ST_TXEMPTY])
        else $error("transmit empty not set");
    a_collision: assert property (coll |=> stat_reg[ST_COLL])
        else $error("collision not flagged");
    a_overfill: assert property (tx_wr && !tx_in_ready |=> stat_reg[ST_OVER])
        else $error("overfill not flagged");
    a_status_view: assert property (SFR_RD && SFR_ADDR == ADDR_STATUS |=> SFR_RDATA[3:2] != 2'b01
        && SFR_RDATA[ST_BUSY] == $past(state_reg != S_IDLE)) else $error("bad status view");
endmodule

//--- hdl/i2c_seq_pkg.sv
/*
 * Constants and types shared by the I2C master sequencer.
 * Assumes an 8-bit special-function-register port on the core clock.
 */
package i2c_seq_pkg;

    // ----------------------------------------------------------------
    // register offsets on the function-register port
    // ----------------------------------------------------------------
    localparam logic [7:0] ADDR_TXBUF  = 8'h9A;
    localparam logic [7:0] ADDR_RXBUF  = 8'h9B;
    localparam logic [7:0] ADDR_MODE   = 8'hE8;
    localparam logic [7:0] ADDR_TARGET = 8'hE9;
    localparam logic [7:0] ADDR_STATUS = 8'hEA;
    localparam logic [7:0] RESET_BYTE  = 8'h00;

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int MODE_EN      = 7;
    localparam int MODE_RATE_HI = 6;
    localparam int MODE_RATE_LO = 5;
    localparam int MODE_RCT_HI  = 4;
    localparam int TGT_DIR      = 0;
    localparam int ST_BUSY      = 7;
    localparam int ST_NOACK     = 6;
    localparam int ST_RXPEND    = 5;
    localparam int ST_TXEMPTY   = 4;
    localparam int ST_COLL      = 1;
    localparam int ST_OVER      = 0;
    localparam logic [7:0] STICKY_MASK = 8'h73;

    // ----------------------------------------------------------------
    // queue level codes and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] LVL_EMPTY = 2'h0;
    localparam logic [1:0] LVL_HALF  = 2'h2;
    localparam logic [1:0] LVL_FULL  = 2'h3;
    // core clocks per quarter scl period at the fastest rate (core/16)
    localparam logic [6:0] QTR_BASE  = 7'h04;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_START = 3'b001,
        S_BIT   = 3'b010,
        S_ACK   = 3'b011,
        S_STOP  = 3'b100
    } seq_state_t;

endpackage

//--- bench/i2c_target_model.sv
/*
 * Behavioural I2C target for the sequencer bench.
 * Assumes pull-ups on both lines; it never stretches the clock.
 */
`timescale 1ns/1ps

// ----------------------------------------------------------------
// target answering one address, counting frames and bytes
// ----------------------------------------------------------------
module i2c_target_model #(
    parameter logic [6:0] MY_ADDR = 7'h2A
) (
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_pull_n,
    output logic [7:0]      last_byte,
    output int              n_wr,
    output int              n_rd,
    output int              n_start,
    output int              n_stop
);
    logic [7:0] sh;
    logic [7:0] cur;
    int         bitn;
    logic       addr_ph;
    logic       sel;
    logic       tx;

    assign cur = 8'hC5 + 8'(n_rd);

    // start and stop seen as data edges while the clock is high
    initial begin
        sda_pull_n = 1'b1;
        {n_wr, n_rd, n_start, n_stop, bitn} = '0;
        {addr_ph, sel, tx} = '0;
    end
    always @(negedge sda) begin
        if (scl === 1'b1) begin
            n_start++;
            bitn = 0;
            addr_ph = 1'b1;
            tx = 1'b0;
        end
    end
    always @(posedge sda) begin
        if (scl === 1'b1) begin
            n_stop++;
            {addr_ph, sel, tx} = '0;
        end
    end

    // sample on the rising clock; a released ack slot ends our sending
    always @(posedge scl) begin
        if (bitn < 8)
            sh = {sh[6:0], sda};
        else if (tx && sda)
            tx = 1'b0;
        bitn = (bitn == 8) ? 0 : bitn + 1;
    end

    // change our pull only after the falling clock, as the bus demands
    always @(negedge scl) begin
        sda_pull_n = 1'b1;
        if (bitn == 8 && !tx) begin
            if (addr_ph) begin
                sel = (sh[7:1] == MY_ADDR);
                tx = sel && sh[0];
            end else if (sel) begin
                last_byte = sh;
                n_wr++;
            end
            sda_pull_n = !sel;
            addr_ph = 1'b0;
        end else if (tx && bitn == 8) begin
            n_rd++;
        end else if (tx) begin
            sda_pull_n = cur[7 - bitn];
        end
    end
endmodule

//--- bench/i2c_master_sequencer_tb.sv
/*
 * Self-checking bench for the I2C master sequencer.
 * Assumes the target model above on a pulled-up two-wire bus.
 */
`timescale 1ns/1ps

module i2c_master_sequencer_tb;
    import i2c_seq_pkg::*;

    typedef struct { logic [7:0] a; logic [7:0] d; logic [7:0] e; } row_t;

    localparam logic [6:0] TADDR = 7'h2A;
    logic       ref_clk, rst, sfr_wr, sfr_rd, scl_o, sda_o;
    logic       scl_oe_n, sda_oe_n, pull_n, scl_line, sda_line;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, last_byte, s;
    int         n_wr, n_rd, n_start, n_stop, s0, p0;
    int         num_errors = 0;
    int         tests_run = 0;
    row_t       rows [4] = '{'{ADDR_TARGET, 8'h55, 8'h55}, '{ADDR_STATUS, 8'hFF, 8'h00},
                             '{8'h10, 8'hFF, 8'h00}, '{ADDR_MODE, 8'h80, 8'h80}};

    // wired-and lines with pull-ups
    assign scl_line = scl_oe_n;
    assign sda_line = sda_oe_n & pull_n;

    i2c_master_seq u_i2c_master_seq (.REF_CLK(ref_clk), .RST(rst), .SFR_ADDR(sfr_addr),
        .SFR_WR(sfr_wr), .SFR_RD(sfr_rd), .SFR_WDATA(sfr_wdata), .SFR_RDATA(sfr_rdata),
        .SCL_I(scl_line), .SCL_O(scl_o), .SCL_OE_N(scl_oe_n), .SDA_I(sda_line),
        .SDA_O(sda_o), .SDA_OE_N(sda_oe_n));
    i2c_target_model #(.MY_ADDR(TADDR)) u_i2c_target_model (.scl(scl_line), .sda(sda_line),
        .sda_pull_n(pull_n), .last_byte(last_byte), .n_wr(n_wr), .n_rd(n_rd),
        .n_start(n_start), .n_stop(n_stop));

    // ----------------------------------------------------------------
    // register port tasks, driven on the falling edge
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
        tests_run++;
        if ((got & m) !== (exp & m)) begin
            num_errors++;
            $display("unexpected at %0t: got %h want %h mask %h", $time, got, exp, m);
        end
    endtask
    // read data lands one edge after the take, then holds
    task automatic rc(input logic [7:0] a, input logic [7:0] exp, input logic [7:0] m);
        @(negedge ref_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
        @(negedge ref_clk);
        s = sfr_rdata;
        chk(s, exp, m);
    endtask
    // bounded poll, so a stuck engine shows as a failed compare
    task automatic wait_idle;
        repeat (20) @(negedge ref_clk);
        rc(ADDR_STATUS, 8'h80, 8'h80);
        for (int i = 0; i < 2000 && s[ST_BUSY] !== 1'b0; i++)
            rc(ADDR_STATUS, 8'h00, 8'h00);
        chk(s, 8'h00, 8'h80);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d, mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // clock and watchdog
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    initial begin
        #100000;
        num_errors++;
        $display("unexpected at %0t: watchdog expired", $time);
        end_of_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst, sfr_wr, sfr_rd, sfr_addr, sfr_wdata} = {1'b1, 18'h0};
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rc(rows[i].a, rows[i].e, 8'hFF);
        end
        $display("register rows done");
        // third byte into a two-deep queue is refused
        wr(ADDR_TXBUF, 8'h3C);
        wr(ADDR_TXBUF, 8'h96);
        wr(ADDR_TXBUF, 8'h11);
        rc(ADDR_STATUS, 8'h0D, 8'hFF);
        wr(ADDR_STATUS, 8'h00);
        rc(ADDR_STATUS, 8'h0C, 8'hFF);
        $display("overfill done");
        // write transfer drains both bytes then stops on an empty queue
        wr(ADDR_TARGET, {TADDR, 1'b0});
        wait_idle();
        chk(last_byte, 8'h96, 8'hFF);
        chk(8'(n_wr), 8'h02, 8'hFF);
        rc(ADDR_STATUS, 8'h10, 8'hDC);
        $display("write transfer done");
        // read of count plus one bytes, acked then nacked
        wr(ADDR_STATUS, 8'h00);
        wr(ADDR_MODE, 8'h81);
        wr(ADDR_TARGET, {TADDR, 1'b1});
        wait_idle();
        rc(ADDR_STATUS, 8'h2C, 8'hFC);
        chk(8'(n_rd), 8'h02, 8'hFF);
        rc(ADDR_RXBUF, 8'hC5, 8'hFF);
        rc(ADDR_RXBUF, 8'hC6, 8'hFF);
        wr(ADDR_STATUS, 8'h00);
        rc(ADDR_STATUS, 8'h00, 8'h2C);
        $display("read transfer done");
        // nobody answers: sticky flag and flushed queue
        wr(ADDR_MODE, 8'h80);
        wr(ADDR_TXBUF, 8'h5A);
        wr(ADDR_TARGET, {7'h11, 1'b0});
        wait_idle();
        rc(ADDR_STATUS, 8'h40, 8'hCC);
        wr(ADDR_STATUS, 8'h00);
        rc(ADDR_STATUS, 8'h00, 8'h40);
        $display("missing ack done");
        // rewrite mid-write chains a read behind a repeated start
        s0 = n_start;
        p0 = n_stop;
        wr(ADDR_TXBUF, 8'h77);
        wr(ADDR_TARGET, {TADDR, 1'b0});
        repeat (60) @(negedge ref_clk);
        wr(ADDR_TARGET, {TADDR, 1'b1});
        wait_idle();
        chk(8'(n_start - s0), 8'h02, 8'hFF);
        chk(8'(n_stop - p0), 8'h01, 8'hFF);
        chk(last_byte, 8'h77, 8'hFF);
        rc(ADDR_RXBUF, 8'hC7, 8'hFF);
        chk({6'h00, scl_o, sda_o}, 8'h00, 8'hFF);
        $display("repeated start done");
        // both strobes on the transmit buffer in one cycle
        @(negedge ref_clk);
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = {ADDR_TXBUF, 8'hA5, 2'b11};
        @(negedge ref_clk);
        {sfr_wr, sfr_rd} = 2'b00;
        rc(ADDR_STATUS, 8'h02, 8'h02);
        $display("collision done");
        // reset in mid-run clears the registers
        @(negedge ref_clk);
        rst = 1'b1;
        repeat (3) @(negedge ref_clk);
        rst = 1'b0;
        rc(ADDR_TARGET, 8'h00, 8'hFF);
        rc(ADDR_STATUS, 8'h00, 8'hFF);
        rc(ADDR_MODE, 8'h00, 8'hFF);
        $display("reset done");
        end_of_test();
    end
endmodule
